// file: verilog/eqrs_sequencer.sv
/*
  Wake qualification, device state, config bits, rail sequencing,
  undervoltage first-crossing events and microcontroller reset release.
  Assumes requests come from same-clock SPI logic; rail band comparators
  are asynchronous and pass a synchroniser here.
*/
`include "eqrs_consts.svh"

module eqrs_sequencer
  import eqrs_pkg::*;
#(
  parameter int unsigned DET_CYC   = `EQRS_WAKE_DET_CYC,
  parameter int unsigned FILT_CYC  = `EQRS_WAKE_FILT_CYC,
  parameter int unsigned PRIMARY_BUCK_RAIL_CYC = `EQRS_RISE_PRIMARY_BUCK_RAIL_CYC,
  parameter int unsigned CORE_BUCK_RAIL_CYC = `EQRS_RISE_CORE_BUCK_RAIL_CYC,
  parameter int unsigned BOOST_CYC = `EQRS_RISE_BOOST_CYC,
  parameter int unsigned STG_CYC   = `EQRS_STG_CYC,
  parameter int unsigned CNT_W     = 18,
  parameter int unsigned RST_W     = 12
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Wake pin
  input  wire logic                       wake_input_pin,
  // State requests
  input  wire logic                       sw_disable_req,
  input  wire logic                       lock_req,
  input  wire logic                       hard_reset_req,
  // Configuration
  input  wire logic                       cfg_wr,
  input  wire logic                       cfg_style_in,
  input  wire logic [1:0]                 cfg_delay_sel_in,
  input  wire logic                       stg_resp_change,
  input  wire logic                       irq_clear,
  // Rail monitors
  input  wire logic [`EQRS_NUM_RAILS-1:0] rail_in_band_pin,
  input  wire logic [`EQRS_NUM_RAILS-1:0] rail_used,
  // Status
  output eqrs_state_type                  dev_state,
  output logic                            wake_level_status,
  output logic                            wake_event_irq_flag,
  output logic                            wake_trigger_style_select,
  output logic [1:0]                      reset_release_delay_sel,
  output eqrs_stage_type                  seq_stage,
  output logic                            stg_fault,
  // Rails
  output logic [`EQRS_NUM_RAILS-1:0]      rail_enable,
  output logic [`EQRS_NUM_RAILS-1:0]      uv_mon_enable,
  output logic [`EQRS_NUM_RAILS-1:0]      uv_event,
  output logic                            mcu_reset_out_n
);

  localparam int unsigned      NR      = `EQRS_NUM_RAILS;
  localparam logic [CNT_W-1:0] STG_LIM = CNT_W'(STG_CYC - 1);

  // ==========================================================
  // Functions
  function automatic logic [CNT_W-1:0] rise_cyc(input int unsigned idx);
    rise_cyc = '0;
    if (idx == `EQRS_RAIL_PRIMARY_BUCK_RAIL) rise_cyc = CNT_W'(PRIMARY_BUCK_RAIL_CYC); // RL22
    if (idx == `EQRS_RAIL_CORE_BUCK_RAIL) rise_cyc = CNT_W'(CORE_BUCK_RAIL_CYC); // RL22
    if (idx == `EQRS_RAIL_BOOST) rise_cyc = CNT_W'(BOOST_CYC); // RL22
  endfunction

  // Rails switched on once the given stage is reached
  function automatic logic [NR-1:0] stage_mask(input eqrs_stage_type s);
    stage_mask = '0;
    if (s >= `EQRS_STAGE_PRIM) stage_mask[`EQRS_RAIL_PRIMARY_BUCK_RAIL] = 1'b1; // RL14
    if (s >= `EQRS_STAGE_CORE) begin
      stage_mask[`EQRS_RAIL_CORE_BUCK_RAIL] = 1'b1;
      stage_mask[`EQRS_RAIL_BOOST] = 1'b1;
    end
    if (s >= `EQRS_STAGE_EXT) begin
      stage_mask[`EQRS_RAIL_VM1] = 1'b1;
      stage_mask[`EQRS_RAIL_VM2] = 1'b1;
    end
  endfunction

  function automatic logic [RST_W-1:0] delay_cyc(input logic [1:0] sel);
    unique case (sel)
      2'h0: delay_cyc = RST_W'(`EQRS_T_RESDEL0_US * `EQRS_CLK_MHZ);
      2'h1: delay_cyc = RST_W'(`EQRS_T_RESDEL1_US * `EQRS_CLK_MHZ);
      2'h2: delay_cyc = RST_W'(`EQRS_T_RESDEL2_US * `EQRS_CLK_MHZ);
      2'h3: delay_cyc = RST_W'(`EQRS_T_RESDEL3_US * `EQRS_CLK_MHZ);
    endcase
  endfunction

  // ==========================================================
  // Registers
  eqrs_state_type   state_ff;
  eqrs_state_type   nxt_state;
  logic             irq_ff;
  logic             style_ff;
  logic [1:0]       delay_ff;
  logic [NR-1:0]    band_s1_ff;
  logic [NR-1:0]    band_s2_ff;
  logic [NR-1:0]    band_s3_ff;
  logic [NR-1:0]    band_ff;
  eqrs_stage_type   stage_ff;
  logic             down_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             stg_hold_ff;
  logic             stg_ff;
  logic [NR-1:0]    rail_en_ff;
  logic [NR-1:0]    uv_seen_ff;
  logic [NR-1:0]    uv_evt_ff;
  logic [RST_W-1:0] rcnt_ff;
  logic             rst_out_n_ff;
  logic             qual;
  logic             q_rise;
  logic             q_fall;

  // ==========================================================
  // Wake qualification
  eqrs_wake_filter #(
    .DET_CYC  (DET_CYC),
    .FILT_CYC (FILT_CYC),
    .CNT_W    (13)
  ) u_wake_filter (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .pin_raw    (wake_input_pin),
    .qual_level (qual),
    .rise_pulse (q_rise),
    .fall_pulse (q_fall)
  );

  wire lvl_style = style_ff == `EQRS_STYLE_LEVEL;                  // RL9
  // Edge style ignores falls entirely
  wire wake_evt  = q_rise || (lvl_style && q_fall);                // RL4 RL10
  wire lvl_hold  = lvl_style && qual;                              // RL11
  wire sw_dis_ok = (state_ff == ST_ACTIVE) && sw_disable_req && !qual; // RL12
  // Set wins over a clear in the same cycle
  wire nxt_irq   = wake_evt || (irq_ff && !irq_clear);             // RL5

  // Defaults win over a coincident write
  wire       nxt_style = sw_dis_ok ? `EQRS_STYLE_EDGE :            // RL13
                         cfg_wr    ? cfg_style_in : style_ff;
  wire [1:0] nxt_delay = sw_dis_ok ? `EQRS_DELAY_SEL_RST :         // RL13
                         cfg_wr    ? cfg_delay_sel_in : delay_ff;

  // ==========================================================
  // Device state
  wire stg_lock;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_DISABLED: begin
        if (lvl_hold || wake_evt) nxt_state = ST_ACTIVE;           // RL6
      end
      ST_ACTIVE: begin
        // Wake events are only reported here, never acted on
        if (hard_reset_req) nxt_state = ST_HARD_RST;               // RL7
        else if (lock_req || stg_lock) nxt_state = ST_LOCKED;
        else if (sw_dis_ok) nxt_state = ST_DISABLED;
      end
      ST_LOCKED: begin
        if (lvl_hold) nxt_state = ST_ACTIVE;                       // RL11
      end
      ST_HARD_RST: begin
        if (lvl_hold || wake_evt) nxt_state = ST_ACTIVE;           // RL11
      end
    endcase
  end

  // ==========================================================
  // Rail synchroniser: a change counts once stages two and three agree
  wire [NR-1:0] band_agree = ~(band_s2_ff ^ band_s3_ff);
  wire [NR-1:0] nxt_band   = (band_agree & band_s3_ff) | (~band_agree & band_ff);

  // ==========================================================
  // Sequencer
  wire            target   = state_ff == ST_ACTIVE;
  wire            dir_chg  = down_ff == target;
  wire            at_off   = stage_ff == `EQRS_STAGE_OFF;
  wire            at_last  = stage_ff == `EQRS_STAGE_EXT;
  wire            timeout  = cnt_ff == STG_LIM;                     // RL20
  wire eqrs_stage_type stage_dn = eqrs_stage_type'(stage_ff - `EQRS_STAGE_PRIM);
  wire eqrs_stage_type stage_up = eqrs_stage_type'(stage_ff + `EQRS_STAGE_PRIM);
  // Going down, the current stage's rails are already off
  wire eqrs_stage_type en_stage = (down_ff && !at_off) ? stage_dn : stage_ff; // RL24
  wire [NR-1:0]   pend     = stage_mask(stage_ff) & ~stage_mask(stage_dn) & rail_used; // RL16
  wire [NR-1:0]   en_mask  = stage_mask(en_stage) & rail_used;      // RL16
  wire [NR-1:0]   rail_done;
  wire [NR-1:0]   rail_off;

  for (genvar i = 0; i < NR; i++) begin : g_rail
    // Needs both the band and the full rise time
    assign rail_done[i] = !pend[i] || (band_ff[i] && cnt_ff >= rise_cyc(i)); // RL15 RL17
    assign rail_off[i]  = !pend[i] || !band_ff[i];
  end

  wire up_ok   = &rail_done;
  wire dn_ok   = &rail_off;
  wire stg_hit = !down_ff && !at_off && !up_ok && timeout;          // RL20
  assign stg_lock = stg_hit && stg_resp_change;                     // RL20
  wire start   = !dir_chg && !down_ff && at_off;
  wire step_up = !dir_chg && !down_ff && !at_off && !at_last &&
                 (up_ok || (stg_hit && !stg_resp_change));          // RL15 RL20
  // A rail that never leaves its band cannot stall power-down
  wire step_dn = !dir_chg && down_ff && !at_off && (dn_ok || timeout); // RL24
  wire stage_mov = start || step_up || step_dn;

  wire eqrs_stage_type nxt_stage = start   ? `EQRS_STAGE_PRIM :
                                   step_up ? stage_up :
                                   step_dn ? stage_dn : stage_ff;   // RL14
  wire [CNT_W-1:0] nxt_cnt = (dir_chg || stage_mov) ? '0 :          // RL24
                             timeout ? cnt_ff : cnt_ff + 1'b1;
  wire             nxt_stg = stg_hit && !stg_hold_ff;

  // ==========================================================
  // Undervoltage first crossing
  wire [NR-1:0] nxt_uv_evt  = rail_en_ff & band_ff & ~uv_seen_ff;   // RL19
  wire [NR-1:0] nxt_uv_seen = rail_en_ff & (uv_seen_ff | band_ff);  // RL19

  // ==========================================================
  // Microcontroller reset release
  wire             mcu_ok    = rail_en_ff[`EQRS_RAIL_PRIMARY_BUCK_RAIL] && band_ff[`EQRS_RAIL_PRIMARY_BUCK_RAIL];
  wire [RST_W-1:0] rel_lim   = delay_cyc(delay_ff);
  wire             rel_done  = rcnt_ff >= rel_lim;
  wire [RST_W-1:0] nxt_rcnt  = !mcu_ok ? '0 : rel_done ? rcnt_ff : rcnt_ff + 1'b1; // RL21
  // Once released, a later delay select must not pull reset back
  wire             nxt_rel_n = mcu_ok && (rel_done || rst_out_n_ff); // RL21

  // ==========================================================
  // State and config registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ST_DISABLED;
      irq_ff   <= 1'b0;
      style_ff <= `EQRS_STYLE_EDGE;                                 // RL10
      delay_ff <= `EQRS_DELAY_SEL_RST;
    end else begin
      state_ff <= nxt_state;
      irq_ff   <= nxt_irq;
      style_ff <= nxt_style;
      delay_ff <= nxt_delay;
    end
  end

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      band_s1_ff  <= '0;
      band_s2_ff  <= '0;
      band_s3_ff  <= '0;
      band_ff     <= '0;
      stage_ff    <= `EQRS_STAGE_OFF;
      down_ff     <= 1'b1;
      cnt_ff      <= '0;
      stg_hold_ff <= 1'b0;
      stg_ff      <= 1'b0;
      rail_en_ff  <= '0;
    end else begin
      band_s1_ff  <= rail_in_band_pin;
      band_s2_ff  <= band_s1_ff;
      band_s3_ff  <= band_s2_ff;
      band_ff     <= nxt_band;
      stage_ff    <= nxt_stage;
      down_ff     <= !target;
      cnt_ff      <= nxt_cnt;
      stg_hold_ff <= stg_hit;
      stg_ff      <= nxt_stg;
      rail_en_ff  <= en_mask;
    end
  end

  // ==========================================================
  // Monitor and reset registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uv_seen_ff   <= '0;
      uv_evt_ff    <= '0;
      rcnt_ff      <= '0;
      rst_out_n_ff <= 1'b0;
    end else begin
      uv_seen_ff   <= nxt_uv_seen;
      uv_evt_ff    <= nxt_uv_evt;
      rcnt_ff      <= nxt_rcnt;
      rst_out_n_ff <= nxt_rel_n;
    end
  end

  // ==========================================================
  // Outputs
  assign dev_state                 = state_ff;
  assign wake_level_status         = qual;                          // RL8
  assign wake_event_irq_flag       = irq_ff;
  assign wake_trigger_style_select = style_ff;
  assign reset_release_delay_sel   = delay_ff;
  assign seq_stage                 = stage_ff;
  assign stg_fault                 = stg_ff;
  assign rail_enable               = rail_en_ff;
  // Monitoring follows the enable exactly
  assign uv_mon_enable             = rail_en_ff;                    // RL18
  assign uv_event                  = uv_evt_ff;
  assign mcu_reset_out_n           = rst_out_n_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_active_left;
    state_ff == ST_ACTIVE ##1 state_ff == ST_DISABLED;
  endsequence

  AST_IRQ_SET: assert property (wake_evt |=> irq_ff) // RL5
    else $error("wake event did not set flag");
  AST_EDGE_ONLY_RISE: assert property (!lvl_style && q_fall && !q_rise |=> irq_ff == $past(irq_ff && !irq_clear)) // RL10
    else $error("fall raised event in edge style");
  AST_NO_SELF_OFF: assert property (state_ff == ST_ACTIVE && !sw_disable_req |=> state_ff != ST_DISABLED) // RL7
    else $error("device left active without request");
  AST_DIS_LOW: assert property (s_active_left |-> !$past(qual)) // RL12
    else $error("disabled entered with wake high");
  AST_CFG_DEFAULT: assert property (s_active_left |-> style_ff == `EQRS_STYLE_EDGE && delay_ff == `EQRS_DELAY_SEL_RST) // RL13
    else $error("config not restored on disable");
  AST_LVL_RETURN: assert property (lvl_hold && state_ff != ST_ACTIVE |=> state_ff == ST_ACTIVE) // RL11
    else $error("level style did not return to active");
  AST_CORE_AFTER_PRIM: assert property ($rose(rail_en_ff[`EQRS_RAIL_CORE_BUCK_RAIL]) && rail_used[`EQRS_RAIL_PRIMARY_BUCK_RAIL]
    |-> $past(band_ff[`EQRS_RAIL_PRIMARY_BUCK_RAIL], 2) || $past(stg_hit, 2)) // RL15
    else $error("core stage started before primary in band");
  AST_RISE_TIME: assert property (stage_ff == `EQRS_STAGE_PRIM && step_up && rail_used[`EQRS_RAIL_PRIMARY_BUCK_RAIL] && !stg_hit
    |-> cnt_ff >= CNT_W'(PRIMARY_BUCK_RAIL_CYC)) // RL17
    else $error("stage advanced before rise time");
  AST_UV_ONCE: assert property (uv_evt_ff[`EQRS_RAIL_PRIMARY_BUCK_RAIL] ##1 rail_en_ff[`EQRS_RAIL_PRIMARY_BUCK_RAIL]
    |-> !uv_evt_ff[`EQRS_RAIL_PRIMARY_BUCK_RAIL]) // RL19
    else $error("undervoltage crossing reported twice");
  AST_STG_TIME: assert property ($rose(stg_ff) |-> $past(cnt_ff) == STG_LIM) // RL20
    else $error("timeout fault at wrong count");
  AST_RST_DELAY: assert property ($rose(rst_out_n_ff) |-> $past(mcu_ok) && $past(rcnt_ff) >= $past(rel_lim)) // RL21
    else $error("reset released early");

endmodule // eqrs_sequencer

// file: pkg/eqrs_consts.svh
/*
  Constants of the wake qualifier and rail sequencer: timing figures,
  derived cycle counts, rail indices, stage codes, state codes, resets.
  Assumes a 125 MHz ref_clk; included by bare name.
*/
// Contract
// RL1: Qualified wake goes high only after the pin stays high for the detect time.
// RL2: Qualified wake goes low only after the pin stays low for the detect time.
// RL3: Excursions shorter than the filter time leave the qualified level unchanged.
// RL4: Qualified rise and fall are both wake events, subject to trigger style.
// RL5: Every wake event sets the sticky wake interrupt flag.
// RL6: A wake event may change device state, e.g. power up from disabled.
// RL7: A wake event never shuts the device down; software decides that.
// RL8: A status bit always shows the current qualified wake level.
// RL9: Software selects edge or level trigger style; the device follows it.
// RL10: Reset default is edge style; only a qualified rise is then an event.
// RL11: Level style with wake high returns the device to ACTIVE from any state.
// RL12: ACTIVE goes to DISABLED only while the qualified wake is low.
// RL13: Software-requested DISABLED entry restores the config register defaults.
// RL14: Rails power in three stages: primary buck, core buck and boost, monitors.
// RL15: A stage starts only once the preceding rail is within its band.
// RL16: Sequencing runs on every enable or disable; unused rails are skipped.
// RL17: A stage completes when its rail is in band and rise time elapsed.
// RL18: Undervoltage monitoring of a rail starts when the rail is enabled.
// RL19: During ramp-up the undervoltage event is reported once, at first crossing.
// RL20: A rail not valid within the timeout faults; response locks or continues.
// RL21: Reset output releases after the supply stays in band for the chosen delay.
// RL22: Rise times are 640 us for primary buck and boost, 320 us for core.
// RL23: Deglitch is a saturating counter after a synchroniser, cleared on change; the counter here clears at the detect limit instead of saturating.
// RL24: Sequencer holds one stage index and one counter; disables step backwards.
`ifndef EQRS_CONSTS_SVH
`define EQRS_CONSTS_SVH

// ==========================================================
// Timing
`define EQRS_CLK_MHZ          125
`define EQRS_T_WAKE_DET_US    40
`define EQRS_T_WAKE_FILT_US   20
`define EQRS_WAKE_DET_CYC     (`EQRS_T_WAKE_DET_US * `EQRS_CLK_MHZ)
`define EQRS_WAKE_FILT_CYC    (`EQRS_T_WAKE_FILT_US * `EQRS_CLK_MHZ)
`define EQRS_T_RISE_PRIMARY_BUCK_RAIL_US  640
`define EQRS_T_RISE_CORE_BUCK_RAIL_US  320
`define EQRS_T_RISE_BOOST_US  640
`define EQRS_RISE_PRIMARY_BUCK_RAIL_CYC   (`EQRS_T_RISE_PRIMARY_BUCK_RAIL_US * `EQRS_CLK_MHZ)
`define EQRS_RISE_CORE_BUCK_RAIL_CYC   (`EQRS_T_RISE_CORE_BUCK_RAIL_US * `EQRS_CLK_MHZ)
`define EQRS_RISE_BOOST_CYC   (`EQRS_T_RISE_BOOST_US * `EQRS_CLK_MHZ)
`define EQRS_T_STG_US         2000
`define EQRS_STG_CYC          (`EQRS_T_STG_US * `EQRS_CLK_MHZ)
`define EQRS_T_RESDEL0_US     8
`define EQRS_T_RESDEL1_US     16
`define EQRS_T_RESDEL2_US     24
`define EQRS_T_RESDEL3_US     32

// ==========================================================
// Rails, stages, states, config
`define EQRS_NUM_RAILS        5
`define EQRS_RAIL_PRIMARY_BUCK_RAIL       0
`define EQRS_RAIL_CORE_BUCK_RAIL       1
`define EQRS_RAIL_BOOST       2
`define EQRS_RAIL_VM1         3
`define EQRS_RAIL_VM2         4
`define EQRS_STAGE_OFF        2'h0
`define EQRS_STAGE_PRIM       2'h1
`define EQRS_STAGE_CORE       2'h2
`define EQRS_STAGE_EXT        2'h3
`define EQRS_ST_DISABLED      2'h0
`define EQRS_ST_ACTIVE        2'h1
`define EQRS_ST_LOCKED        2'h3
`define EQRS_ST_HARD_RST      2'h2
`define EQRS_STYLE_EDGE       1'h0
`define EQRS_STYLE_LEVEL      1'h1
`define EQRS_DELAY_SEL_RST    2'h0

`endif

// file: pkg/eqrs_pkg.sv
/*
  Types of the wake qualifier and rail sequencer.
  Assumes eqrs_consts.svh is on the include path.
*/
`include "eqrs_consts.svh"

package eqrs_pkg;

  // Gray along DISABLED, ACTIVE, LOCKED, HARD_RST
  typedef enum logic [1:0] {
    ST_DISABLED = `EQRS_ST_DISABLED,
    ST_ACTIVE   = `EQRS_ST_ACTIVE,
    ST_LOCKED   = `EQRS_ST_LOCKED,
    ST_HARD_RST = `EQRS_ST_HARD_RST
  } eqrs_state_type;

  typedef logic [1:0] eqrs_stage_type;

endpackage

// file: verilog/eqrs_wake_filter.sv
/*
  Wake pin deglitch: three-flop synchroniser, agreement stage and
  a duration counter that flips the qualified level.
  Assumes the pin is asynchronous to ref_clk.
*/
`include "eqrs_consts.svh"

module eqrs_wake_filter
  import eqrs_pkg::*;
#(
  parameter int unsigned DET_CYC  = `EQRS_WAKE_DET_CYC,
  parameter int unsigned FILT_CYC = `EQRS_WAKE_FILT_CYC,
  parameter int unsigned CNT_W    = 13
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Raw pin
  input  wire logic pin_raw,
  // Qualified level and its edges
  output logic      qual_level,
  output logic      rise_pulse,
  output logic      fall_pulse
);

  localparam logic [CNT_W-1:0] DET_LIM  = CNT_W'(DET_CYC - 1);
  localparam logic [CNT_W-1:0] FILT_LIM = CNT_W'(FILT_CYC);

  logic [2:0]       sync_ff;
  logic             agreed_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic             qual_ff;
  logic             rise_ff;
  logic             fall_ff;

  // ==========================================================
  // Decode
  wire             agree    = sync_ff[1] == sync_ff[2];
  wire             differs  = agreed_ff != qual_ff;
  wire             at_lim   = cnt_ff == DET_LIM;
  wire             flip     = differs && at_lim;
  // Any return of the agreed level clears the count
  wire [CNT_W-1:0] nxt_cnt  = (!differs || at_lim) ? '0 : cnt_ff + 1'b1; // RL23
  wire             nxt_qual = flip ? agreed_ff : qual_ff;                // RL1 RL2 RL3

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_ff   <= 3'h0;
      agreed_ff <= 1'b0;
      cnt_ff    <= '0;
      qual_ff   <= 1'b0;
      rise_ff   <= 1'b0;
      fall_ff   <= 1'b0;
    end else begin
      sync_ff   <= {sync_ff[1:0], pin_raw};
      agreed_ff <= agree ? sync_ff[2] : agreed_ff;
      cnt_ff    <= nxt_cnt;
      qual_ff   <= nxt_qual;
      rise_ff   <= flip && agreed_ff;
      fall_ff   <= flip && !agreed_ff;
    end
  end

  assign qual_level = qual_ff;
  assign rise_pulse = rise_ff;
  assign fall_pulse = fall_ff;

  // ==========================================================
  // Checks
  AST_QUAL_RISE: assert property (@(posedge ref_clk) disable iff (rst) // RL1
    $rose(qual_ff) |-> $past(cnt_ff) == DET_LIM && $past(agreed_ff))
    else $error("qualified high without full detect time");
  AST_QUAL_FALL: assert property (@(posedge ref_clk) disable iff (rst) // RL2
    $fell(qual_ff) |-> $past(cnt_ff) == DET_LIM && !$past(agreed_ff))
    else $error("qualified low without full detect time");
  AST_GLITCH: assert property (@(posedge ref_clk) disable iff (rst) // RL3
    (differs && cnt_ff < FILT_LIM) ##1 !differs |-> $stable(qual_ff))
    else $error("short excursion changed qualified level");

endmodule // eqrs_wake_filter

// file: sim/eqrs_rail_model.sv
/*
  Regulator and monitor stand-in: each rail enters its band three
  cycles after its enable rises and leaves it three cycles after release.
  Assumes one ref_clk shared with the sequencer.
*/
module eqrs_rail_model (
  // Clock
  input  wire logic       ref_clk,
  // Enables in, band status out
  input  wire logic [4:0] rail_enable,
  output logic      [4:0] rail_in_band_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Ramp delay
  // Short ramp, so the rise time and not the rail limits the primary and core stages
  logic [4:0] ramp1_ff;
  logic [4:0] ramp2_ff;
  always_ff @(posedge ref_clk) begin
    ramp1_ff         <= rail_enable;
    ramp2_ff         <= ramp1_ff;
    rail_in_band_pin <= ramp2_ff;
  end
endmodule // eqrs_rail_model

// file: sim/eqrs_sequencer_tb_top.sv
/*
  Bench of the wake qualifier and rail sequencer with shortened counts.
  Assumes eqrs_rail_model answers the rail enables.
*/
module eqrs_sequencer_tb_top
  import eqrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic           ref_clk = 1'b0;
  logic           rst     = 1'b1;
  logic           pin     = 1'b0;
  logic           dis     = 1'b0;
  logic           lock    = 1'b0;
  logic           cfg_wr  = 1'b0;
  logic           style   = 1'b0;
  logic           irq_clr = 1'b0;
  logic [1:0]     dly      = 2'h0;
  logic           resp_chg = 1'b0;
  logic [4:0]     used     = 5'h1f;
  // Masked enables stand for a rail that never reaches its band
  logic [4:0]     stuck    = 5'h00;
  logic [1:0]     dly_out;
  logic           stg_flt;
  logic [4:0]     uv_ev;
  int             uv_cnt   = 0;
  int             flt_cnt  = 0;
  logic [4:0]     band;
  logic [4:0]     rail_enable;
  logic [4:0]     uv_mon_enable;
  logic           wake_level_status;
  logic           wake_event_irq_flag;
  logic           wake_trigger_style_select;
  logic           mcu_reset_out_n;
  eqrs_state_type dev_state;
  eqrs_stage_type seq_stage;
  int             num_errors = 0;
  int             cmp_count  = 0;
  int             n;
  wire logic [7:0] cnd = {dev_state === ST_LOCKED, dev_state === ST_ACTIVE, mcu_reset_out_n === 1'b1,
                          seq_stage === 2'h0,
                          seq_stage === 2'h3, seq_stage === 2'h2, wake_level_status === 1'b0,
                          wake_level_status === 1'b1};
  always #4 ref_clk = ~ref_clk;
  // ==========================================================
  // Design and rails
  eqrs_sequencer #(.PRIMARY_BUCK_RAIL_CYC(40), .CORE_BUCK_RAIL_CYC(20), .BOOST_CYC(40),
    .STG_CYC(100)) dut_u (.ref_clk(ref_clk), .rst(rst), .wake_input_pin(pin), .sw_disable_req(dis),
    .lock_req(lock), .hard_reset_req(1'b0), .cfg_wr(cfg_wr), .cfg_style_in(style), .cfg_delay_sel_in(dly),
    .stg_resp_change(resp_chg), .irq_clear(irq_clr), .rail_in_band_pin(band), .rail_used(used),
    .dev_state(dev_state), .wake_level_status(wake_level_status), .wake_event_irq_flag(wake_event_irq_flag),
    .wake_trigger_style_select(wake_trigger_style_select), .reset_release_delay_sel(dly_out),
    .seq_stage(seq_stage), .stg_fault(stg_flt), .rail_enable(rail_enable), .uv_mon_enable(uv_mon_enable),
    .uv_event(uv_ev), .mcu_reset_out_n(mcu_reset_out_n));
  eqrs_rail_model rail_u (.ref_clk(ref_clk), .rail_enable(rail_enable & ~stuck), .rail_in_band_pin(band));
  // Pulse outputs stand one cycle, so they are counted at every edge
  always @(posedge ref_clk) begin
    uv_cnt  <= uv_cnt + $countones(uv_ev);
    flt_cnt <= flt_cnt + $countones(stg_flt);
  end
  // ==========================================================
  // Tasks
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [4:0] seen, input logic [4:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait on one condition bit
  task wt(input int b, input int lim, output int k);
    for (k = 0; k < lim && cnd[b] !== 1'b1; k++) tick(1);
    if (cnd[b] !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: wait on condition %0d timed out", $time, b);
      test_done();
    end
  endtask
  task test_done();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    tick(20);
    rst = 1'b0;
    tick(2);
    chk(5'(dev_state), 5'(ST_DISABLED));
    chk(5'(wake_trigger_style_select), 5'h0);
    pin = 1'b1;
    tick(8);
    pin = 1'b0;
    tick(40);
    chk(5'(wake_level_status), 5'h0);
    chk(5'(wake_event_irq_flag), 5'h0);
    pin = 1'b1;
    tick(4990);
    chk(5'(wake_level_status), 5'h0);
    wt(0, 40, n);
    tick(1);
    chk(5'(wake_event_irq_flag), 5'h1);
    chk(5'(dev_state), 5'(ST_ACTIVE));
    wt(2, 200, n);
    chk(5'(n >= 40), 5'h1);
    chk(rail_enable, 5'h01);
    wt(3, 200, n);
    chk(rail_enable, 5'h07);
    chk(5'(mcu_reset_out_n), 5'h0);
    tick(2);
    chk(rail_enable, 5'h1f);
    chk(uv_mon_enable, 5'h1f);
    wt(5, 1100, n);
    chk(5'(n > 800), 5'h1);
    chk(5'(uv_cnt), 5'h05);
    irq_clr = 1'b1;
    tick(1);
    irq_clr = 1'b0;
    pin = 1'b0;
    tick(4990);
    chk(5'(wake_level_status), 5'h1);
    wt(1, 40, n);
    tick(2);
    chk(5'(wake_event_irq_flag), 5'h0);
    chk(5'(dev_state), 5'(ST_ACTIVE));
    pin = 1'b1;
    wt(0, 5100, n);
    dis = 1'b1;
    tick(1);
    dis = 1'b0;
    tick(2);
    chk(5'(dev_state), 5'(ST_ACTIVE));
    cfg_wr = 1'b1;
    style = 1'b1;
    dly = 2'h2;
    tick(1);
    cfg_wr = 1'b0;
    chk(5'(wake_trigger_style_select), 5'h1);
    chk(5'(dly_out), 5'h2);
    lock = 1'b1;
    tick(1);
    lock = 1'b0;
    chk(5'(dev_state), 5'(ST_LOCKED));
    chk(5'(mcu_reset_out_n), 5'h1);
    wt(6, 5, n);
    irq_clr = 1'b1;
    tick(1);
    irq_clr = 1'b0;
    pin = 1'b0;
    wt(1, 5100, n);
    tick(2);
    chk(5'(wake_event_irq_flag), 5'h1);
    chk(5'(dev_state), 5'(ST_ACTIVE));
    dis = 1'b1;
    tick(1);
    dis = 1'b0;
    tick(1);
    chk(5'(dev_state), 5'(ST_DISABLED));
    chk(5'(wake_trigger_style_select), 5'h0);
    chk(5'(dly_out), 5'h0);
    wt(4, 400, n);
    chk(rail_enable, 5'h00);
    stuck = 5'h02;
    resp_chg = 1'b1;
    pin = 1'b1;
    wt(6, 5100, n);
    wt(7, 300, n);
    tick(1);
    chk(5'(flt_cnt), 5'h01);
    chk(5'(seq_stage), 5'h2);
    test_done();
  end
endmodule // eqrs_sequencer_tb_top
